// file: pkg/etf_pkg.sv
// Constants for the event-triggered sample buffer: register map, field layout,
// mode encodings, reset values and buffer geometry.
// Assumes an APB slave with 32-bit data and byte addresses on an 8-bit paddr.
package etf_pkg;

    // Buffer geometry
    localparam int DATA_W = 16;
    localparam int PTR_W = 12;
    localparam int CNT_W = 13;
    localparam int PADDR_W = 8;
    localparam logic [PTR_W-1:0] DEPTH_CAP = 12'hFFF;

    // Register byte offsets
    localparam logic [PADDR_W-1:0] OFF_WTM_LOW = 8'h00;
    localparam logic [PADDR_W-1:0] OFF_WTM_HIGH = 8'h04;
    localparam logic [PADDR_W-1:0] OFF_DEC_A = 8'h08;
    localparam logic [PADDR_W-1:0] OFF_DEC_B = 8'h0C;
    localparam logic [PADDR_W-1:0] OFF_RATE_MODE = 8'h10;
    localparam logic [PADDR_W-1:0] OFF_GEN_CTRL4 = 8'h14;
    localparam logic [PADDR_W-1:0] OFF_LINE1_ROUTE = 8'h18;
    localparam logic [PADDR_W-1:0] OFF_LINE2_ROUTE = 8'h1C;
    localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h20;
    localparam logic [PADDR_W-1:0] OFF_DATA = 8'h24;

    // Field widths and positions
    localparam int BYTE_W = 8;
    localparam int WTM_HIGH_W = 4;
    localparam int MODE_W = 3;
    localparam int MODE_LSB = 0;
    localparam int RATE_W = 4;
    localparam int RATE_LSB = 3;
    localparam int LIMIT_BIT = 0;
    localparam int LINE1_W = 2;
    localparam int LINE2_W = 6;
    localparam int DET_W = 8;
    localparam int DET_LINE2_LSB = 2;

    // Status register bit positions, above the 12-bit stored count
    localparam int ST_EMPTY = 12;
    localparam int ST_OVERRUN = 13;
    localparam int ST_FULL = 14;
    localparam int ST_WTM = 15;
    localparam int ST_HALTED = 16;
    localparam int ST_EVENT = 17;
    localparam int ST_BEHAV_LSB = 18;

    // Mode field encodings
    localparam logic [MODE_W-1:0] MODE_IDLE = 3'h0;
    localparam logic [MODE_W-1:0] MODE_FIFO = 3'h1;
    localparam logic [MODE_W-1:0] MODE_CONT_STOP = 3'h3;
    localparam logic [MODE_W-1:0] MODE_IDLE_CONT = 3'h4;
    localparam logic [MODE_W-1:0] MODE_CONT = 3'h6;

    // Reset values
    localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Visible buffer behaviour, Gray coded along clear -> fill -> halt
    typedef enum logic [1:0] {
        BH_CLEAR = 2'b00,
        BH_FILL = 2'b01,
        BH_HALT = 2'b11
    } etf_behav_t;

endpackage

// file: core/etf_event_router.sv
// Event router: combines the detector levels enabled on line 1 and line 2
// into the single buffer event level.
// Assumes detector levels come from logic on the same clock.
`timescale 1ns/1ps
module etf_event_router (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Detector levels and routing enables
    input wire logic [etf_pkg::DET_W-1:0] detect_i,
    input wire logic [etf_pkg::LINE1_W-1:0] route1_i,
    input wire logic [etf_pkg::LINE2_W-1:0] route2_i,
    // Routed lines and event level
    output logic line1_o,
    output logic line2_o,
    output logic event_o
);
    logic next_line1;
    logic next_line2;

    // Motion and step go to line 1, the gesture detectors to line 2
    assign next_line1 = |(detect_i[etf_pkg::LINE1_W-1:0] & route1_i);
    assign next_line2 = |(detect_i[etf_pkg::DET_W-1:etf_pkg::DET_LINE2_LSB] & route2_i);

    // Registered so the level is stable over a whole write slot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line1_o <= 1'b0;
            line2_o <= 1'b0;
            event_o <= 1'b0;
        end else begin
            line1_o <= next_line1;
            line2_o <= next_line2;
            event_o <= next_line1 | next_line2;
        end
    end
endmodule

// file: core/etf_buffer_top.sv
// Event-triggered sample buffer: storage, mode control and APB registers.
// Assumes a sample strobe and detector levels from logic on CLOCK_I.
//
// Behaviour
// - Continuous-then-stop overwrites first, then stops when full once event is active.
// - Mode code 011b selects continuous-then-stop.
// - Mode code 100b selects idle-then-continuous.
// - Event is any enabled detector routed to line 1 or line 2.
// - Continuous-then-stop follows event level; losing event resumes overwriting.
// - Continuous-then-stop keeps filling; full flags one write before full.
// - Threshold limit bit caps depth at watermark; full when next write reaches it.
// - Event while full stops storing at the first sample after it.
// - Event before ever full keeps storing until full, then stops if still present.
// - Idle-then-continuous stays cleared until the event appears.
// - Idle-then-continuous is level based; losing event returns to cleared idle.
// - After switching, idle-then-continuous fills and flags full one write early.
// - Mode 000b clears the buffer and keeps it empty.
// - Continuous full buffer overwrites oldest entries and sets overrun.
`timescale 1ns/1ps
module etf_buffer_top (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [etf_pkg::PADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Sample stream
    input wire logic SAMPLE_STB_I,
    input wire logic [etf_pkg::DATA_W-1:0] SAMPLE_DATA_I,
    // Detector levels
    input wire logic [etf_pkg::DET_W-1:0] DETECT_I,
    // Status
    output logic BUF_FULL_O,
    output logic BUF_EMPTY_O,
    output logic BUF_OVERRUN_O,
    output logic BUF_WTM_O,
    output logic LINE1_O,
    output logic LINE2_O
);
    // Sample storage
    logic [etf_pkg::DATA_W-1:0] mem [0:(1 << etf_pkg::PTR_W)-1];

    // Configuration registers
    logic [etf_pkg::BYTE_W-1:0] watermark_low_control;
    logic [etf_pkg::WTM_HIGH_W-1:0] watermark_high_control;
    logic [etf_pkg::BYTE_W-1:0] decimation_control_a;
    logic [etf_pkg::BYTE_W-1:0] decimation_control_b;
    logic [etf_pkg::MODE_W-1:0] buffer_mode;
    logic [etf_pkg::RATE_W-1:0] buffer_rate;
    logic threshold_limit_bit;
    logic [etf_pkg::LINE1_W-1:0] line1_route_control;
    logic [etf_pkg::LINE2_W-1:0] line2_function_route;

    // Buffer state
    logic [etf_pkg::PTR_W-1:0] wr_ptr;
    logic [etf_pkg::PTR_W-1:0] rd_ptr;
    logic [etf_pkg::PTR_W-1:0] count;
    etf_pkg::etf_behav_t behav;
    logic event_lvl;

    // Decode and decision signals
    logic setup_ph;
    logic access_done;
    logic wr_done;
    logic pop;
    logic store;
    logic drop;
    logic clear;
    etf_pkg::etf_behav_t next_behav;
    logic [etf_pkg::PTR_W-1:0] watermark_level;
    logic [etf_pkg::PTR_W-1:0] cap;
    logic [etf_pkg::CNT_W-1:0] next_count_w;
    logic [etf_pkg::PTR_W-1:0] next_count;
    logic next_full;
    logic addr_ok;
    logic [31:0] rd_mux;

    assign watermark_level = {watermark_high_control, watermark_low_control};
    assign setup_ph = PSEL_I & ~PENABLE_I;
    assign access_done = PSEL_I & PENABLE_I & PREADY_O;
    assign wr_done = access_done & PWRITE_I;

    // Usable depth shrinks to the watermark when the limit bit is set
    assign cap = threshold_limit_bit ? watermark_level : etf_pkg::DEPTH_CAP;

    // A data-register read removes the oldest word, never from an empty buffer
    assign pop = access_done & ~PWRITE_I & (PADDR_I == etf_pkg::OFF_DATA)
                 & (count != '0) & (buffer_mode != etf_pkg::MODE_IDLE);

    // Event levels routed from the detectors
    etf_event_router u_router (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .detect_i(DETECT_I),
        .route1_i(line1_route_control),
        .route2_i(line2_function_route),
        .line1_o(LINE1_O),
        .line2_o(LINE2_O),
        .event_o(event_lvl)
    );

    // Per-slot decision; the event level is only looked at on a write slot
    always_comb begin
        store = 1'b0;
        drop = 1'b0;
        clear = 1'b0;
        next_behav = behav;
        if (buffer_mode == etf_pkg::MODE_IDLE) begin
            clear = 1'b1;
            next_behav = etf_pkg::BH_CLEAR;
        end else if (SAMPLE_STB_I) begin
            case (buffer_mode)
                etf_pkg::MODE_FIFO: begin
                    store = ~BUF_FULL_O;
                    next_behav = BUF_FULL_O ? etf_pkg::BH_HALT : etf_pkg::BH_FILL;
                end
                etf_pkg::MODE_CONT: begin
                    store = 1'b1;
                    drop = BUF_FULL_O & ~pop;
                    next_behav = etf_pkg::BH_FILL;
                end
                etf_pkg::MODE_CONT_STOP: begin
                    // Stop only when the event is present and the buffer is full;
                    // an early event lets filling carry on until full
                    if (event_lvl & BUF_FULL_O) begin
                        next_behav = etf_pkg::BH_HALT;
                    end else begin
                        store = 1'b1;
                        drop = BUF_FULL_O & ~pop;
                        next_behav = etf_pkg::BH_FILL;
                    end
                end
                etf_pkg::MODE_IDLE_CONT: begin
                    if (event_lvl) begin
                        store = 1'b1;
                        drop = BUF_FULL_O & ~pop;
                        next_behav = etf_pkg::BH_FILL;
                    end else begin
                        clear = 1'b1;
                        next_behav = etf_pkg::BH_CLEAR;
                    end
                end
                default: begin
                    // Unused codes clear the buffer on each write slot so nothing stale is kept
                    clear = 1'b1;
                    next_behav = etf_pkg::BH_CLEAR;
                end
            endcase
        end
    end

    // Count after this cycle; drop and pop never both happen
    always_comb begin
        next_count_w = {1'b0, count};
        if (clear) begin
            next_count_w = '0;
        end else begin
            next_count_w = next_count_w + {{(etf_pkg::CNT_W-1){1'b0}}, store}
                           - {{(etf_pkg::CNT_W-1){1'b0}}, pop}
                           - {{(etf_pkg::CNT_W-1){1'b0}}, drop};
        end
        next_count = next_count_w[etf_pkg::PTR_W-1:0];
        // Full is flagged once the next write would reach the usable depth
        next_full = ((next_count_w + 1'b1) >= {1'b0, cap});
    end

    // Sample storage write
    always_ff @(posedge CLOCK_I) begin
        if (store) begin
            mem[wr_ptr] <= SAMPLE_DATA_I;
        end
    end

    // Pointers and count; overwriting advances the read side past the oldest
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (store) begin
                wr_ptr <= (wr_ptr == cap) ? '0 : wr_ptr + 1'b1;
            end
            if (pop | drop) begin
                rd_ptr <= (rd_ptr == cap) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
        end
    end

    // Visible behaviour state
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            behav <= etf_pkg::BH_CLEAR;
        end else begin
            behav <= next_behav;
        end
    end

    // Status flags; overrun holds until the buffer is cleared
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            BUF_FULL_O <= 1'b0;
            BUF_EMPTY_O <= 1'b1;
            BUF_OVERRUN_O <= 1'b0;
            BUF_WTM_O <= 1'b0;
        end else begin
            BUF_FULL_O <= next_full;
            BUF_EMPTY_O <= (next_count == '0);
            BUF_WTM_O <= (next_count >= watermark_level);
            if (clear) begin
                BUF_OVERRUN_O <= 1'b0;
            end else if (drop) begin
                BUF_OVERRUN_O <= 1'b1;
            end
        end
    end

    // Watermark and decimation registers; decimation is only stored and read back
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            watermark_low_control <= etf_pkg::RST_BYTE;
            watermark_high_control <= '0;
            decimation_control_a <= etf_pkg::RST_BYTE;
            decimation_control_b <= etf_pkg::RST_BYTE;
        end else if (wr_done) begin
            case (PADDR_I)
                etf_pkg::OFF_WTM_LOW: watermark_low_control <= PWDATA_I[etf_pkg::BYTE_W-1:0];
                etf_pkg::OFF_WTM_HIGH: begin
                    watermark_high_control <= PWDATA_I[etf_pkg::WTM_HIGH_W-1:0];
                end
                etf_pkg::OFF_DEC_A: decimation_control_a <= PWDATA_I[etf_pkg::BYTE_W-1:0];
                etf_pkg::OFF_DEC_B: decimation_control_b <= PWDATA_I[etf_pkg::BYTE_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Rate and mode; a mode write takes effect on the next cycle
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            buffer_mode <= etf_pkg::MODE_IDLE;
            buffer_rate <= '0;
        end else if (wr_done && PADDR_I == etf_pkg::OFF_RATE_MODE) begin
            buffer_mode <= PWDATA_I[etf_pkg::MODE_LSB +: etf_pkg::MODE_W];
            buffer_rate <= PWDATA_I[etf_pkg::RATE_LSB +: etf_pkg::RATE_W];
        end
    end

    // Limit bit and event routing
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            threshold_limit_bit <= 1'b0;
            line1_route_control <= '0;
            line2_function_route <= '0;
        end else if (wr_done) begin
            case (PADDR_I)
                etf_pkg::OFF_GEN_CTRL4: threshold_limit_bit <= PWDATA_I[etf_pkg::LIMIT_BIT];
                etf_pkg::OFF_LINE1_ROUTE: begin
                    line1_route_control <= PWDATA_I[etf_pkg::LINE1_W-1:0];
                end
                etf_pkg::OFF_LINE2_ROUTE: begin
                    line2_function_route <= PWDATA_I[etf_pkg::LINE2_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Address check covers every register slot
    always_comb begin
        case (PADDR_I)
            etf_pkg::OFF_WTM_LOW, etf_pkg::OFF_WTM_HIGH, etf_pkg::OFF_DEC_A,
            etf_pkg::OFF_DEC_B, etf_pkg::OFF_RATE_MODE, etf_pkg::OFF_GEN_CTRL4,
            etf_pkg::OFF_LINE1_ROUTE, etf_pkg::OFF_LINE2_ROUTE, etf_pkg::OFF_STATUS,
            etf_pkg::OFF_DATA: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Read mux for the plain registers
    always_comb begin
        rd_mux = etf_pkg::RST_WORD;
        case (PADDR_I)
            etf_pkg::OFF_WTM_LOW: rd_mux[etf_pkg::BYTE_W-1:0] = watermark_low_control;
            etf_pkg::OFF_WTM_HIGH: rd_mux[etf_pkg::WTM_HIGH_W-1:0] = watermark_high_control;
            etf_pkg::OFF_DEC_A: rd_mux[etf_pkg::BYTE_W-1:0] = decimation_control_a;
            etf_pkg::OFF_DEC_B: rd_mux[etf_pkg::BYTE_W-1:0] = decimation_control_b;
            etf_pkg::OFF_RATE_MODE: begin
                rd_mux[etf_pkg::MODE_LSB +: etf_pkg::MODE_W] = buffer_mode;
                rd_mux[etf_pkg::RATE_LSB +: etf_pkg::RATE_W] = buffer_rate;
            end
            etf_pkg::OFF_GEN_CTRL4: rd_mux[etf_pkg::LIMIT_BIT] = threshold_limit_bit;
            etf_pkg::OFF_LINE1_ROUTE: rd_mux[etf_pkg::LINE1_W-1:0] = line1_route_control;
            etf_pkg::OFF_LINE2_ROUTE: rd_mux[etf_pkg::LINE2_W-1:0] = line2_function_route;
            etf_pkg::OFF_STATUS: begin
                rd_mux[etf_pkg::PTR_W-1:0] = count;
                rd_mux[etf_pkg::ST_EMPTY] = BUF_EMPTY_O;
                rd_mux[etf_pkg::ST_OVERRUN] = BUF_OVERRUN_O;
                rd_mux[etf_pkg::ST_FULL] = BUF_FULL_O;
                rd_mux[etf_pkg::ST_WTM] = BUF_WTM_O;
                rd_mux[etf_pkg::ST_HALTED] = (behav == etf_pkg::BH_HALT);
                rd_mux[etf_pkg::ST_EVENT] = event_lvl;
                rd_mux[etf_pkg::ST_BEHAV_LSB +: 2] = behav;
            end
            default: rd_mux = etf_pkg::RST_WORD;
        endcase
    end

    // APB answer: data captured in setup, ready high for the first access cycle.
    // The oldest word is sampled in setup; an overwrite in the same cycle can
    // shift it, so the host should read a halted or slow-filling buffer.
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= etf_pkg::RST_WORD;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= setup_ph;
            if (setup_ph) begin
                PSLVERR_O <= ~addr_ok;
                if (PWRITE_I) begin
                    PRDATA_O <= etf_pkg::RST_WORD;
                end else if (PADDR_I == etf_pkg::OFF_DATA) begin
                    PRDATA_O <= {{(32-etf_pkg::DATA_W){1'b0}}, mem[rd_ptr]};
                end else begin
                    PRDATA_O <= rd_mux;
                end
            end else begin
                PSLVERR_O <= 1'b0;
            end
        end
    end

endmodule

// file: dv/etf_buffer_asserts.sv
// Checker for the event-triggered buffer: flag causes and APB answer timing.
// Assumes it is bound to etf_buffer_top and sees only its ports.
`timescale 1ns/1ps
module etf_buffer_asserts (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    // Inputs watched as causes
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic SAMPLE_STB_I,
    input wire logic [etf_pkg::DET_W-1:0] DETECT_I,
    // Outputs under check
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic BUF_FULL_O,
    input wire logic BUF_EMPTY_O,
    input wire logic BUF_OVERRUN_O,
    input wire logic LINE1_O,
    input wire logic LINE2_O
);
    // One clock domain, so clock and reset are stated once
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    // Flags straight out of reset
    reset_state_a: assert property (
        $fell(SYS_RST_I) |-> BUF_EMPTY_O && !BUF_FULL_O && !BUF_OVERRUN_O)
        else $error("flags wrong after reset");
    // Loss is only possible when a slot arrives at a full buffer
    overrun_cause_a: assert property (
        $rose(BUF_OVERRUN_O) |-> $past(SAMPLE_STB_I) && $past(BUF_FULL_O))
        else $error("overrun without a write at full");
    // Storing happens only on a write slot
    store_slot_a: assert property ($fell(BUF_EMPTY_O) |-> $past(SAMPLE_STB_I))
        else $error("buffer filled outside a slot");
    // Full rises from a stored sample or a new depth setting
    full_cause_a: assert property (
        $rose(BUF_FULL_O) |-> $past(SAMPLE_STB_I) || $past(PSEL_I) || $past(PSEL_I, 2))
        else $error("full rose without cause");
    // Clearing comes from a slot without event, a pop or a mode write
    clear_cause_a: assert property (
        $rose(BUF_EMPTY_O) |-> $past(SAMPLE_STB_I) || $past(PSEL_I) || $past(PSEL_I, 2))
        else $error("buffer cleared without cause");
    // Routed lines follow their own detector groups
    line1_cause_a: assert property ($rose(LINE1_O) |-> |$past(DETECT_I[1:0]))
        else $error("line 1 rose without its detector");
    line2_cause_a: assert property ($rose(LINE2_O) |-> |$past(DETECT_I[7:2]))
        else $error("line 2 rose without its detector");
    // One access cycle, then ready drops
    ready_slot_a: assert property ($rose(PSEL_I) |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not a single access cycle");
    error_data_a: assert property (PREADY_O && PSLVERR_O |-> PRDATA_O == 32'h0000_0000)
        else $error("error answer carries data");
endmodule

bind etf_buffer_top etf_buffer_asserts chk_u (
    .CLOCK_I(CLOCK_I),
    .SYS_RST_I(SYS_RST_I),
    .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I),
    .SAMPLE_STB_I(SAMPLE_STB_I),
    .DETECT_I(DETECT_I),
    .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O),
    .BUF_FULL_O(BUF_FULL_O),
    .BUF_EMPTY_O(BUF_EMPTY_O),
    .BUF_OVERRUN_O(BUF_OVERRUN_O),
    .LINE1_O(LINE1_O),
    .LINE2_O(LINE2_O)
);

// file: dv/etf_host_model.sv
// Host processor model: APB master that configures and reads the buffer.
// Assumes the slave raises pready during the access phase.
`timescale 1ns/1ps
module etf_host_model (
    // Clock
    input wire logic clk_i,
    // APB master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [etf_pkg::PADDR_W-1:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    logic [31:0] rdata;
    logic rerr;
    // Bus idle until the first transfer
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0000_0000;
    end
    // One transfer; the request holds until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        rdata = prdata_i;
        rerr = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
    // Event routing first, then decimation, then rate with the mode last
    task automatic setup(input logic [1:0] r1, input logic [5:0] r2, input logic [2:0] m);
        xfer(1'b1, etf_pkg::OFF_LINE1_ROUTE, {30'h0, r1});
        xfer(1'b1, etf_pkg::OFF_LINE2_ROUTE, {26'h0, r2});
        xfer(1'b1, etf_pkg::OFF_DEC_A, 32'h0000_0001);
        xfer(1'b1, etf_pkg::OFF_DEC_B, 32'h0000_0001);
        xfer(1'b1, etf_pkg::OFF_RATE_MODE, {25'h0, 4'h2, m});
    endtask
    // Reset through idle; 30 us settle at 4 ns before any other mode
    task automatic clear_buf();
        xfer(1'b1, etf_pkg::OFF_RATE_MODE, 32'h0000_0000);
        repeat (7500) @(posedge clk_i);
    endtask
endmodule

// file: dv/etf_buffer_top_tb.sv
// Testbench for the event-triggered buffer: APB host plus sample and detector drive.
// Assumes the checker is bound to the top and the host model drives APB.
`timescale 1ns/1ps
module etf_buffer_top_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, stb;
    logic full, empty, ovr, wtm, line1, line2;
    logic [7:0] paddr, det;
    logic [31:0] pwdata, prdata, s;
    logic [15:0] sdat;
    logic [11:0] c;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    etf_buffer_top dut_u (.CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SAMPLE_STB_I(stb),
        .SAMPLE_DATA_I(sdat), .DETECT_I(det), .BUF_FULL_O(full), .BUF_EMPTY_O(empty),
        .BUF_OVERRUN_O(ovr), .BUF_WTM_O(wtm), .LINE1_O(line1), .LINE2_O(line2));
    etf_host_model host_u (.clk_i(clk), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
        .pready_i(pready), .pslverr_i(pslverr));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Verdict and end of run
    task automatic stop_test();
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, well above the expected run of about 15k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // One write slot; ends at the falling edge so flags have settled
    task automatic put(input logic [15:0] d);
        @(posedge clk);
        stb <= 1'b1;
        sdat <= d;
        @(posedge clk);
        stb <= 1'b0;
        sdat <= ~d;
        @(negedge clk);
    endtask
    // Detector level change, given time to pass the router
    task automatic evt(input logic [7:0] d);
        @(posedge clk);
        det <= d;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic stat();
        host_u.xfer(1'b0, etf_pkg::OFF_STATUS, 32'h0000_0000);
        s = host_u.rdata;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        stb = 1'b0;
        sdat = 16'h0000;
        det = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        stat();
        chk(s, 32'h0000_9000);
        host_u.xfer(1'b0, 8'h40, 32'h0000_0000);
        chk(host_u.rdata, 32'h0000_0000);
        chk(host_u.rerr, 1'b1);
        // Depth limited to a watermark of 4: full once 3 are stored
        host_u.xfer(1'b1, etf_pkg::OFF_WTM_LOW, 32'h0000_0004);
        host_u.xfer(1'b1, etf_pkg::OFF_WTM_HIGH, 32'h0000_0000);
        host_u.xfer(1'b1, etf_pkg::OFF_GEN_CTRL4, 32'h0000_0001);
        host_u.xfer(1'b0, etf_pkg::OFF_WTM_LOW, 32'h0000_0000);
        chk(host_u.rdata, 32'h0000_0004);
        // Every detector reaches its own line
        host_u.setup(2'b11, 6'h3F, etf_pkg::MODE_IDLE);
        for (int i = 0; i < 8; i++) begin
            evt(8'h01 << i);
            chk(line1, i < 2);
            chk(line2, i >= 2);
        end
        evt(8'h00);
        // Event present before the buffer ever filled
        host_u.setup(2'b01, 6'h00, etf_pkg::MODE_CONT_STOP);
        evt(8'h01);
        for (int i = 0; i < 3; i++) put(16'h0100 + i[15:0]);
        chk(full, 1'b1);
        chk(wtm, 1'b0);
        put(16'h0200);
        stat();
        chk(s[11:0], 12'h003);
        chk(s[etf_pkg::ST_HALTED], 1'b1);
        chk(s[etf_pkg::ST_OVERRUN], 1'b0);
        // Event gone: overwriting resumes and loses the oldest
        evt(8'h00);
        put(16'h0300);
        put(16'h0301);
        stat();
        chk(s[etf_pkg::ST_HALTED], 1'b0);
        chk(ovr, 1'b1);
        // Event while already full stops at the next slot
        evt(8'h01);
        put(16'h0400);
        stat();
        chk(s[etf_pkg::ST_HALTED], 1'b1);
        c = s[11:0];
        put(16'h0401);
        stat();
        chk(s[11:0], c);
        // Count alone cannot tell a halt from an overwrite; the oldest word can
        host_u.xfer(1'b0, etf_pkg::OFF_DATA, 32'h0000_0000);
        chk(host_u.rdata, 32'h0000_0102);
        host_u.clear_buf();
        chk(empty, 1'b1);
        stat();
        chk(s[12:0], 13'h1000);
        // Idle-then-continuous driven by a line 2 detector
        evt(8'h00);
        host_u.setup(2'b00, 6'h01, etf_pkg::MODE_IDLE_CONT);
        put(16'h1111);
        chk(empty, 1'b1);
        evt(8'h04);
        chk(empty, 1'b1);
        put(16'hA5A5);
        put(16'h0F0F);
        put(16'h3C3C);
        chk(full, 1'b1);
        host_u.xfer(1'b0, etf_pkg::OFF_DATA, 32'h0000_0000);
        chk(host_u.rdata, 32'h0000_A5A5);
        stat();
        chk(s[11:0], 12'h002);
        evt(8'h00);
        put(16'h7777);
        chk(empty, 1'b1);
        host_u.clear_buf();
        // Plain continuous overwrite, then stop-when-full on the same content
        host_u.setup(2'b00, 6'h00, etf_pkg::MODE_CONT);
        for (int i = 0; i < 4; i++) put(16'h0500 + i[15:0]);
        chk(ovr, 1'b1);
        host_u.xfer(1'b1, etf_pkg::OFF_RATE_MODE, {25'h0, 4'h2, etf_pkg::MODE_FIFO});
        put(16'h0600);
        stat();
        chk(s[etf_pkg::ST_HALTED], 1'b1);
        host_u.xfer(1'b0, etf_pkg::OFF_DATA, 32'h0000_0000);
        chk(host_u.rdata, 32'h0000_0501);
        stop_test();
    end
endmodule
